// ---- design/master_test_irq.sv ----
`timescale 1ns/1ps
`include "master_test_cfg.svh"
module master_test_irq
   import master_test_pkg::*;
#(
   parameter int NUM_FRAMERS = `NUM_DS2_FRAMERS
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic soft_rst,
   input wire logic chip_select_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [`ADDR_W-1:0] addr,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   input wire logic receive_variable_clock,
   output logic test_clock,
   output logic blocks_test_mode,
   output logic factory_test_active,
   output logic pins_tristate,
   input wire logic tx_link_irq,
   input wire logic ds2_ds3_mux_irq,
   input wire logic ds3_framer_irq,
   input wire logic rx_link_irq,
   input wire logic rx_link_end_of_msg,
   input wire logic alarm_code_detector_irq,
   input wire logic tx_link_underrun,
   input wire logic [NUM_FRAMERS-1:0] ds2_framer_irq,
   input wire logic [7:0] mux_source,
   input wire logic rx_external_link_select,
   input wire logic tx_external_link_select,
   input wire logic link_pins_open_drain,
   output logic rx_link_irq_pin_out,
   output logic rx_link_irq_pin_oe,
   output logic rx_link_eom_pin_out,
   output logic rx_link_eom_pin_oe,
   output logic tx_link_irq_pin_out,
   output logic tx_link_irq_pin_oe,
   output logic tx_link_underrun_pin_out,
   output logic tx_link_underrun_pin_oe
);
   typedef struct packed {
      logic soft_test_clock;
      logic factory_test_mode;
      logic bus_drive_by_select;
      logic board_test_mode;
      logic data_bus_tristate;
      logic outputs_tristate;
      reg_byte_t primary;
      reg_byte_t framers;
      reg_byte_t data_out;
      logic data_oe;
      logic test_clock;
      logic blocks_test;
      logic factory_active;
      logic pins_tristate;
      logic [3:0] pin_out;
      logic [3:0] pin_oe;
      logic wr_prev;
      bus_state_t bus;
   } core_state_t;

   core_state_t state_reg;
   core_state_t state_next;

   logic cs_n_s;
   logic rd_n_s;
   logic wr_n_s;
   logic rvclk_s;
   logic [`ADDR_W-1:0] addr_s;
   logic [7:0] data_in_s;
   logic [3:0] link_raw;
   logic [3:0] link_sel;

   sync_2ff #(
      .WIDTH(4),
      .RESET_VALUE(4'hE)
   ) u_sync (
      .clock(clock),
      .sys_rst(sys_rst),
      .async_in({chip_select_n, rd_n, wr_n, receive_variable_clock}),
      .sync_out({cs_n_s, rd_n_s, wr_n_s, rvclk_s})
   );

   // Address and write data share the strobes' latency
   sync_2ff #(
      .WIDTH(`ADDR_W + 8)
   ) u_sync_bus (
      .clock(clock),
      .sys_rst(sys_rst),
      .async_in({addr, data_in}),
      .sync_out({addr_s, data_in_s})
   );

   assign link_raw = {tx_link_underrun, tx_link_irq, rx_link_end_of_msg, rx_link_irq};
   assign link_sel = {tx_external_link_select, tx_external_link_select,
                      rx_external_link_select, rx_external_link_select};

   always_comb begin
      logic in_test;
      logic wr_strobe;
      logic [3:0] pin_active;
      state_next = state_reg;
      in_test = state_reg.board_test_mode | state_reg.factory_test_mode;
      wr_strobe = !cs_n_s && !wr_n_s && state_reg.wr_prev;
      pin_active = 4'h0;
      state_next.wr_prev = wr_n_s;
      // Register writes on the falling write strobe
      if (wr_strobe && soft_rst == 1'b0) begin
         if (addr_s == `OFS_MASTER_TEST_CONTROL) begin
            state_next.soft_test_clock = data_in_s[`BIT_SOFT_TEST_CLOCK];
            state_next.bus_drive_by_select = data_in_s[`BIT_BUS_DRIVE_BY_SELECT];
            state_next.board_test_mode = data_in_s[`BIT_BOARD_TEST_MODE];
            state_next.data_bus_tristate = data_in_s[`BIT_DATA_BUS_TRISTATE];
            state_next.outputs_tristate = data_in_s[`BIT_OUTPUTS_TRISTATE];
            if (data_in_s[`BIT_FACTORY_TEST_MODE]) begin
               state_next.factory_test_mode = 1'b1;
            end
         end
      end
      if (cs_n_s) begin
         state_next.factory_test_mode = 1'b0;
      end
      // Live source registers, no latch
      state_next.framers = 8'h00;
      for (int i = 0; i < NUM_FRAMERS; i++) begin
         state_next.framers[i] = ds2_framer_irq[i];
      end
      state_next.framers[`BIT_TX_LINK_UNDERRUN] = tx_link_underrun;
      state_next.primary[`BIT_FRAMER_GROUP_PENDING] = |state_next.framers;
      state_next.primary[`BIT_MUX_GROUP_PENDING] = |mux_source;
      state_next.primary[`BIT_TX_LINK_IRQ] = tx_link_irq;
      state_next.primary[`BIT_DS2_DS3_MUX_IRQ] = ds2_ds3_mux_irq;
      state_next.primary[`BIT_DS3_FRAMER_IRQ] = ds3_framer_irq;
      state_next.primary[`BIT_RX_LINK_IRQ] = rx_link_irq;
      state_next.primary[`BIT_RX_LINK_END_OF_MSG] = rx_link_end_of_msg;
      state_next.primary[`BIT_ALARM_CODE_DETECTOR_IRQ] = alarm_code_detector_irq;
      // Read path; reading has no side effect
      state_next.data_out = 8'h00;
      state_next.bus = bus_idle;
      if (!cs_n_s && !rd_n_s) begin
         state_next.bus = bus_access;
         case (addr_s)
            `OFS_MASTER_TEST_CONTROL: begin
               state_next.data_out[`BIT_SOFT_TEST_CLOCK] = state_reg.soft_test_clock;
               state_next.data_out[`BIT_BOARD_TEST_MODE] = state_reg.board_test_mode;
               state_next.data_out[`BIT_OUTPUTS_TRISTATE] = state_reg.outputs_tristate;
            end
            `OFS_INTERRUPT_SOURCE_PRIMARY: begin
               state_next.data_out = state_reg.primary;
            end
            `OFS_INTERRUPT_SOURCE_FRAMERS: begin
               state_next.data_out = state_reg.framers;
            end
            default: begin
               state_next.data_out = 8'h00;
            end
         endcase
      end
      // Data bus enable
      if (in_test && state_reg.bus_drive_by_select) begin
         state_next.data_oe = cs_n_s;
      end else if (state_reg.data_bus_tristate) begin
         state_next.data_oe = 1'b0;
      end else begin
         state_next.data_oe = (state_next.bus == bus_access);
      end
      state_next.test_clock = state_reg.board_test_mode ? state_reg.soft_test_clock
                                                        : rvclk_s;
      state_next.blocks_test = in_test;
      state_next.factory_active = state_reg.factory_test_mode;
      state_next.pins_tristate = state_reg.outputs_tristate;
      // Link irq pins, internal controller only
      for (int j = 0; j < 4; j++) begin
         pin_active[j] = link_raw[j] & ~link_sel[j];
         if (state_reg.outputs_tristate) begin
            state_next.pin_out[j] = 1'b0;
            state_next.pin_oe[j] = 1'b0;
         end else if (link_pins_open_drain) begin
            state_next.pin_out[j] = 1'b0;
            state_next.pin_oe[j] = pin_active[j];
         end else begin
            state_next.pin_out[j] = pin_active[j];
            state_next.pin_oe[j] = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= '0;
         state_reg.wr_prev <= 1'b1;
         state_reg.bus <= bus_idle;
      end else begin
         state_reg <= state_next;
      end
   end

   assign data_out = state_reg.data_out;
   assign data_oe = state_reg.data_oe;
   assign test_clock = state_reg.test_clock;
   assign blocks_test_mode = state_reg.blocks_test;
   assign factory_test_active = state_reg.factory_active;
   assign pins_tristate = state_reg.pins_tristate;
   assign rx_link_irq_pin_out = state_reg.pin_out[0];
   assign rx_link_irq_pin_oe = state_reg.pin_oe[0];
   assign rx_link_eom_pin_out = state_reg.pin_out[1];
   assign rx_link_eom_pin_oe = state_reg.pin_oe[1];
   assign tx_link_irq_pin_out = state_reg.pin_out[2];
   assign tx_link_irq_pin_oe = state_reg.pin_oe[2];
   assign tx_link_underrun_pin_out = state_reg.pin_out[3];
   assign tx_link_underrun_pin_oe = state_reg.pin_oe[3];
endmodule : master_test_irq

// ---- design/master_test_cfg.svh ----
`ifndef MASTER_TEST_CFG_SVH
`define MASTER_TEST_CFG_SVH
`define ADDR_W 8
`define OFS_MASTER_TEST_CONTROL 8'h07
`define OFS_INTERRUPT_SOURCE_PRIMARY 8'h08
`define OFS_INTERRUPT_SOURCE_FRAMERS 8'h09
`define OFS_INTERRUPT_SOURCE_MUXES 8'h0A
`define BIT_SOFT_TEST_CLOCK 7
`define BIT_FACTORY_TEST_MODE 4
`define BIT_BUS_DRIVE_BY_SELECT 3
`define BIT_BOARD_TEST_MODE 2
`define BIT_DATA_BUS_TRISTATE 1
`define BIT_OUTPUTS_TRISTATE 0
`define BIT_FRAMER_GROUP_PENDING 7
`define BIT_MUX_GROUP_PENDING 6
`define BIT_TX_LINK_IRQ 5
`define BIT_DS2_DS3_MUX_IRQ 4
`define BIT_DS3_FRAMER_IRQ 3
`define BIT_RX_LINK_IRQ 2
`define BIT_RX_LINK_END_OF_MSG 1
`define BIT_ALARM_CODE_DETECTOR_IRQ 0
`define BIT_TX_LINK_UNDERRUN 7
`define NUM_DS2_FRAMERS 7
`define TEST_CONTROL_RESET 8'h00
`endif

// ---- design/master_test_pkg.sv ----
package master_test_pkg;
   typedef logic [7:0] reg_byte_t;
   typedef enum logic [1:0] {
      bus_idle,
      bus_access
   } bus_state_t;
endpackage : master_test_pkg

// ---- design/sync_2ff.sv ----
`timescale 1ns/1ps
module sync_2ff #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } sync_state_t;
   sync_state_t state_reg;
   sync_state_t state_next;
   always_comb begin
      state_next = state_reg;
      state_next.stage1 = async_in;
      state_next.stage2 = state_reg.stage1;
   end
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= {RESET_VALUE, RESET_VALUE};
      end else begin
         state_reg <= state_next;
      end
   end
   assign sync_out = state_reg.stage2;
endmodule : sync_2ff

// ---- verification/master_test_irq_asserts.sv ----
`timescale 1ns/1ps
module master_test_irq_chk (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic chip_select_n,
   input wire logic receive_variable_clock,
   input wire logic test_clock,
   input wire logic blocks_test_mode,
   input wire logic factory_test_active,
   input wire logic data_oe,
   input wire logic pins_tristate,
   input wire logic rx_link_irq,
   input wire logic tx_link_underrun,
   input wire logic rx_external_link_select,
   input wire logic tx_external_link_select,
   input wire logic link_pins_open_drain,
   input wire logic rx_link_irq_pin_oe,
   input wire logic tx_link_underrun_pin_oe
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   logic [2:0] up_reg;
   // Edges since reset, so history is clean
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) up_reg <= 3'h0;
      else if (up_reg != 3'h4) up_reg <= up_reg + 3'h1;
   end
   a_rx_irq_pin: assert property (up_reg == 3'h4 && $past(link_pins_open_drain) &&
      !pins_tristate |-> rx_link_irq_pin_oe == $past(rx_link_irq && !rx_external_link_select))
      else $error("rx irq pin wrong");
   a_udr_pin: assert property (up_reg == 3'h4 && $past(link_pins_open_drain) &&
      !pins_tristate |->
      tx_link_underrun_pin_oe == $past(tx_link_underrun && !tx_external_link_select))
      else $error("underrun pin wrong");
   a_rx_ext_quiet: assert property ((rx_external_link_select && link_pins_open_drain)
      [*2] |-> !rx_link_irq_pin_oe) else $error("rx pin active in external mode");
   a_tx_ext_quiet: assert property ((tx_external_link_select && link_pins_open_drain)
      [*2] |-> !tx_link_underrun_pin_oe) else $error("tx pin active in external mode");
   a_factory_or_board: assert property ($past(factory_test_active) && factory_test_active
      |-> blocks_test_mode) else $error("factory test not in blocks test");
   a_factory_clear: assert property (chip_select_n [*5] |-> !factory_test_active)
      else $error("factory test not cleared");
   a_test_clock_pin: assert property (up_reg == 3'h4 && !blocks_test_mode &&
      !$past(blocks_test_mode) |-> test_clock == $past(receive_variable_clock, 3))
      else $error("test clock not from pin");
   a_idle_no_drive: assert property ((!blocks_test_mode && chip_select_n) [*4] |-> !data_oe)
      else $error("data bus driven outside test");
endmodule : master_test_irq_chk
bind master_test_irq master_test_irq_chk u_chk (.clock, .sys_rst, .chip_select_n,
   .receive_variable_clock, .test_clock, .blocks_test_mode, .factory_test_active, .data_oe,
   .rx_link_irq, .tx_link_underrun, .rx_external_link_select, .tx_external_link_select,
   .link_pins_open_drain, .rx_link_irq_pin_oe, .tx_link_underrun_pin_oe, .pins_tristate);

// ---- verification/cpu_bus_model.sv ----
`timescale 1ns/1ps
module cpu_bus_model (
   input wire logic clock,
   output logic chip_select_n,
   output logic rd_n,
   output logic wr_n,
   output logic [7:0] addr,
   output logic [7:0] data_in,
   input wire logic [7:0] data_out,
   input wire logic data_oe
);
   initial begin
      {chip_select_n, rd_n, wr_n} = 3'h7;
      {addr, data_in} = 16'h0000;
   end
   // Whole byte access, held until the answer is taken
   task automatic cycle(input logic [7:0] a, input logic [7:0] d, input logic w,
         output logic [7:0] q, output logic oe);
      @(posedge clock);
      {addr, data_in, chip_select_n, rd_n, wr_n} <= {a, d, 1'b0, w, ~w};
      repeat (5) @(posedge clock);
      q = data_out;
      oe = data_oe;
      {chip_select_n, rd_n, wr_n} <= 3'h7;
      {addr, data_in} <= ~{a, d};
      repeat (3) @(posedge clock);
   endtask : cycle
endmodule : cpu_bus_model

// ---- verification/master_test_irq_tb.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
$display("ERROR %0t: got %h exp %h", $time, (a), (e)); end end
module master_test_irq_tb;
   logic clock, sys_rst, soft_rst, chip_select_n, rd_n, wr_n, data_oe, receive_variable_clock;
   logic [7:0] addr, data_in, data_out, mux_source, q;
   logic [6:0] ds2_framer_irq;
   logic tx_link_irq, ds2_ds3_mux_irq, ds3_framer_irq, rx_link_irq, rx_link_end_of_msg;
   logic alarm_code_detector_irq, tx_link_underrun, rx_external_link_select, oe;
   logic tx_external_link_select, link_pins_open_drain, test_clock, blocks_test_mode;
   logic factory_test_active, pins_tristate, rx_link_irq_pin_out, rx_link_irq_pin_oe;
   logic rx_link_eom_pin_out, rx_link_eom_pin_oe, tx_link_irq_pin_out, tx_link_irq_pin_oe;
   logic tx_link_underrun_pin_out, tx_link_underrun_pin_oe;
   int miscompares, comparisons;
   wire [3:0] pin_oe = {rx_link_irq_pin_oe, rx_link_eom_pin_oe, tx_link_irq_pin_oe,
      tx_link_underrun_pin_oe};
   wire [3:0] pin_out = {rx_link_irq_pin_out, rx_link_eom_pin_out, tx_link_irq_pin_out,
      tx_link_underrun_pin_out};
   master_test_irq DUT (.clock, .sys_rst, .soft_rst, .chip_select_n, .rd_n, .wr_n, .addr,
      .data_in, .data_out, .data_oe, .receive_variable_clock, .test_clock, .blocks_test_mode,
      .factory_test_active, .pins_tristate, .tx_link_irq, .ds2_ds3_mux_irq, .ds3_framer_irq,
      .rx_link_irq, .rx_link_end_of_msg, .alarm_code_detector_irq, .tx_link_underrun,
      .ds2_framer_irq, .mux_source, .rx_external_link_select, .tx_external_link_select,
      .link_pins_open_drain, .rx_link_irq_pin_out, .rx_link_irq_pin_oe, .rx_link_eom_pin_out,
      .rx_link_eom_pin_oe, .tx_link_irq_pin_out, .tx_link_irq_pin_oe,
      .tx_link_underrun_pin_out, .tx_link_underrun_pin_oe);
   cpu_bus_model cpu (.clock, .chip_select_n, .rd_n, .wr_n, .addr, .data_in, .data_out,
      .data_oe);
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) receive_variable_clock <= ~receive_variable_clock;
   task automatic settle();
      repeat (3) @(negedge clock);
   endtask : settle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      cpu.cycle(a, d, 1'b1, q, oe);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      cpu.cycle(a, 8'h00, 1'b0, q, oe);
      `CHK(q, e)
   endtask : rd
   task automatic test_done();
      $display("miscompares %0d comparisons %0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : test_done
   task automatic t_test_reg();
      rd(8'h07, 8'h00);
      wr(8'h07, 8'h85);
      rd(8'h07, 8'h85);
      `CHK({test_clock, blocks_test_mode, pins_tristate}, 3'h7)
      soft_rst <= 1'b1;
      wr(8'h07, 8'h00);
      rd(8'h07, 8'h85);
      soft_rst <= 1'b0;
      wr(8'h07, 8'h04);
      settle();
      `CHK(test_clock, 1'b0)
      @(posedge clock);
      sys_rst <= 1'b1;
      @(posedge clock);
      sys_rst <= 1'b0;
      rd(8'h07, 8'h00);
      `CHK(pins_tristate, 1'b0)
   endtask : t_test_reg
   task automatic t_factory();
      settle();
      fork
         wr(8'h07, 8'h10);
         begin
            repeat (5) @(negedge clock);
            `CHK({factory_test_active, blocks_test_mode}, 2'h3)
         end
      join
      settle();
      `CHK(factory_test_active, 1'b0)
   endtask : t_factory
   task automatic t_bus();
      rd(8'h08, 8'h00);
      `CHK(oe, 1'b1)
      wr(8'h07, 8'h02);
      cpu.cycle(8'h08, 8'h00, 1'b0, q, oe);
      `CHK(oe, 1'b0)
      wr(8'h07, 8'h08);
      settle();
      `CHK(data_oe, 1'b0)
      cpu.cycle(8'h08, 8'h00, 1'b0, q, oe);
      `CHK(oe, 1'b1)
      wr(8'h07, 8'h0E);
      settle();
      `CHK(data_oe, 1'b1)
      cpu.cycle(8'h08, 8'h00, 1'b0, q, oe);
      `CHK(oe, 1'b0)
      wr(8'h07, 8'h00);
   endtask : t_bus
   task automatic t_irq();
      for (int i = 0; i < 6; i++) begin
         {tx_link_irq, ds2_ds3_mux_irq, ds3_framer_irq, rx_link_irq, rx_link_end_of_msg,
            alarm_code_detector_irq} <= 6'h20 >> i;
         rd(8'h08, 8'h20 >> i);
         rd(8'h08, 8'h20 >> i);
      end
      alarm_code_detector_irq <= 1'b0;
      for (int j = 0; j < 8; j++) begin
         {tx_link_underrun, ds2_framer_irq} <= 8'h01 << j;
         rd(8'h09, 8'h01 << j);
         rd(8'h08, 8'h80);
      end
      {tx_link_underrun, ds2_framer_irq, mux_source} <= 16'h0004;
      rd(8'h08, 8'h40);
      mux_source <= 8'h00;
      rd(8'h08, 8'h00);
   endtask : t_irq
   task automatic t_pins();
      {link_pins_open_drain, rx_link_irq, rx_link_end_of_msg, tx_link_irq} <= 4'hF;
      tx_link_underrun <= 1'b1;
      settle();
      `CHK({pin_oe, pin_out}, 8'hF0)
      @(posedge clock);
      {rx_external_link_select, tx_external_link_select} <= 2'h3;
      settle();
      `CHK(pin_oe, 4'h0)
   endtask : t_pins
   initial begin
      sys_rst = 1'b1;
      {soft_rst, tx_link_irq, ds2_ds3_mux_irq, ds3_framer_irq, rx_link_irq} = '0;
      {rx_link_end_of_msg, alarm_code_detector_irq, tx_link_underrun, ds2_framer_irq} = '0;
      {mux_source, rx_external_link_select, tx_external_link_select} = '0;
      {link_pins_open_drain, receive_variable_clock, miscompares, comparisons} = '0;
      repeat (20) @(posedge clock);
      sys_rst <= 1'b0;
      t_test_reg();
      t_factory();
      t_bus();
      t_irq();
      t_pins();
      test_done();
   end
   initial begin
      repeat (20000) @(posedge clock);
      miscompares++;
      test_done();
   end
endmodule : master_test_irq_tb
